// >>> inc/ccs_params.svh
// Constants for the capture unit: register map, field positions, reset values, counts
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// Register bus widths
`define CCS_ADDR_W 8
`define CCS_DATA_W 8
`define CCS_CNT_W 16

// Register byte offsets
`define CCS_OFS_CTRL 8'h00
`define CCS_OFS_SRC 8'h01
`define CCS_OFS_DATA_LO 8'h02
`define CCS_OFS_DATA_HI 8'h03
`define CCS_OFS_TSEL 8'h04
`define CCS_OFS_STAT 8'h05

// Control register fields
`define CCS_CTRL_EN 7
`define CCS_CTRL_LATCH 5
`define CCS_CTRL_OD 4
`define CCS_CTRL_MODE_HI 3
`define CCS_CTRL_OUT_BIT 3

// Status register fields
`define CCS_STAT_FLAG 0
`define CCS_STAT_IE 1

// Field widths and reset values
`define CCS_SRC_W 3
`define CCS_TSEL_W 2
`define CCS_RST_CTRL 8'h00
`define CCS_RST_SRC 3'h0
`define CCS_RST_TSEL 2'h0
`define CCS_RST_DATA 16'h0000

// Capture sources: the pin plus four on-chip signals
`define CCS_NSRC 5
`define CCS_SRC_PIN 3'h0

// Prescaler terminal counts (every 4th and every 16th rising edge)
`define CCS_PS_W 4
`define CCS_PS_TOP4 4'h3
`define CCS_PS_TOP16 4'hf

// Timer index numbers reported to the timer block
`define CCS_TIDX_W 3

`endif

// >>> inc/ccs_pkg.sv
// Types shared by the capture unit modules
package ccs_pkg;

    // Unit operating mode, low nibble of the control register
    typedef enum logic [3:0] {
        CCS_MODE_OFF    = 4'h0,
        CCS_MODE_ANY    = 4'h3,
        CCS_MODE_FALL   = 4'h4,
        CCS_MODE_RISE   = 4'h5,
        CCS_MODE_RISE4  = 4'h6,
        CCS_MODE_RISE16 = 4'h7
    } ccs_mode_type;

    // Event prescaler setting
    typedef enum logic [1:0] {
        CCS_DIV1  = 2'h0,
        CCS_DIV4  = 2'h1,
        CCS_DIV16 = 2'h2
    } ccs_div_type;

endpackage

// >>> logic/ccs_sync_edge.sv
// Two-stage synchroniser for all capture sources, selection and edge detection
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_sync_edge
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Asynchronous sources and selection
    input wire logic [`CCS_NSRC-1:0] src_async,
    input wire logic [`CCS_SRC_W-1:0] src_sel,
    // Edge pulses of the selected source
    output logic rise,
    output logic fall
);

    // First stage, read only by the second stage
    logic [`CCS_NSRC-1:0] meta_ff;
    // Second stage, safe to use
    logic [`CCS_NSRC-1:0] sync_ff;
    // Previous level of the selected source
    logic prev_ff;
    // Selected synchronised level
    wire logic sel_level;

    // Per-source synchroniser pair
    genvar i;
    generate
        for (i = 0; i < `CCS_NSRC; i = i + 1) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_ff[i] <= 1'b0;
                    sync_ff[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= src_async[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    // Out-of-range selections fall back to the pin
    assign sel_level = (src_sel < `CCS_NSRC) ? sync_ff[src_sel] : sync_ff[`CCS_SRC_PIN];

    // Edge history; a source change can look like an edge, software masks that
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sel_level;
        end
    end

    // One pulse per edge
    assign rise = sel_level & ~prev_ff;
    assign fall = ~sel_level & prev_ff;

endmodule

// >>> logic/ccs_prescaler.sv
// Event prescaler: passes every 1st, 4th or 16th qualifying edge
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_prescaler
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire ccs_div_type div_sel,
    // Events in and out
    input wire logic tick,
    output logic fire,
    output logic [`CCS_PS_W-1:0] count
);

    // Edge counter
    logic [`CCS_PS_W-1:0] count_ff;
    logic [`CCS_PS_W-1:0] nxt_count;
    // Terminal count for the current setting
    wire logic [`CCS_PS_W-1:0] top;

    // Terminal count lookup
    assign top = (div_sel == CCS_DIV16) ? `CCS_PS_TOP16 :
                 (div_sel == CCS_DIV4) ? `CCS_PS_TOP4 : '0;

    // Fire on the edge that reaches the terminal count
    assign fire = ~clr & tick & (count_ff >= top);

    // Clear wins; a setting change keeps the count, so it may fire early
    assign nxt_count = clr ? '0 : fire ? '0 : tick ? count_ff + 4'h1 : count_ff;

    // Counter register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign count = count_ff;

endmodule

// >>> logic/ccs_capture_unit.sv
// Capture unit: copies the assigned timer count on selected input events
//
// Summary of operation
// - Capture copies full sixteen-bit timer count.
// - Mode picks falling, rising, 4th, 16th, any.
// - Capture sets flag; software clears it.
// - New capture overwrites unread data.
// - Capture uses odd timers, PWM even ones.
// - Default timers: first for capture, second PWM.
// - Several units may share one timer.
// - Data readable as low and high bytes.
// - Output modes allow open-drain pin driver.
// - Source select field picks capture input.
// - Pin level captured even when driven.
// - Prescaler cleared when off, non-capture, reset.
// - Prescaler switch keeps count; clear control first.
// - Capture works in sleep with external timer.
// - Sleeping timer holds count, resumes after wake.
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_capture_unit
    import ccs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [`CCS_ADDR_W-1:0] reg_addr,
    input wire logic [`CCS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`CCS_DATA_W-1:0] reg_rdata,
    // Pin and on-chip capture sources
    input wire logic pin_level_in,
    input wire logic [`CCS_NSRC-2:0] chip_src_in,
    input wire logic pin_direction_bit,
    output logic pin_out,
    output logic pin_oe,
    // Timer counts and their clocking state
    input wire logic [`CCS_CNT_W-1:0] tmr1_count,
    input wire logic [`CCS_CNT_W-1:0] tmr3_count,
    input wire logic [`CCS_CNT_W-1:0] tmr5_count,
    input wire logic [2:0] tmr_ext_clk,
    input wire logic sleep_in,
    output logic [`CCS_TIDX_W-1:0] assigned_timer_index,
    // Status
    output logic capture_interrupt_flag,
    output logic capture_irq,
    output logic capture_strobe
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and state

    // Reset release pair
    logic rst_meta_ff;
    logic rst_sync_n;
    // Software registers
    logic [`CCS_DATA_W-1:0] ctrl_ff;
    logic [`CCS_SRC_W-1:0] src_ff;
    logic [`CCS_TSEL_W-1:0] tsel_ff;
    logic ie_ff;
    // Captured data and flag
    logic [`CCS_CNT_W-1:0] data_ff;
    logic [`CCS_CNT_W-1:0] nxt_data;
    logic flag_ff;
    logic nxt_flag;
    // Registered outputs
    logic [`CCS_DATA_W-1:0] rdata_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic irq_ff;
    logic strobe_ff;
    logic [`CCS_TIDX_W-1:0] tidx_ff;

    // Reset is asserted at once and released through two flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_n <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoding

    // Address match used for both writes and reads
    function automatic logic hit(input logic [`CCS_ADDR_W-1:0] a, input logic [`CCS_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    // Write strobes per register
    wire logic wr_ctrl = reg_wr & hit(reg_addr, `CCS_OFS_CTRL);
    wire logic wr_src = reg_wr & hit(reg_addr, `CCS_OFS_SRC);
    wire logic wr_lo = reg_wr & hit(reg_addr, `CCS_OFS_DATA_LO);
    wire logic wr_hi = reg_wr & hit(reg_addr, `CCS_OFS_DATA_HI);
    wire logic wr_tsel = reg_wr & hit(reg_addr, `CCS_OFS_TSEL);
    wire logic wr_stat = reg_wr & hit(reg_addr, `CCS_OFS_STAT);

    // Mode fields
    wire logic unit_en = ctrl_ff[`CCS_CTRL_EN];
    wire ccs_mode_type mode = ccs_mode_type'(ctrl_ff[`CCS_CTRL_MODE_HI:0]);
    wire logic cap_mode = unit_en & ((mode == CCS_MODE_ANY) | (mode == CCS_MODE_FALL) |
                                     (mode == CCS_MODE_RISE) | (mode == CCS_MODE_RISE4) |
                                     (mode == CCS_MODE_RISE16));
    // Compare and PWM modes drive the pin
    wire logic out_mode = unit_en & ctrl_ff[`CCS_CTRL_OUT_BIT];
    // PWM is the upper half of output modes
    wire logic pwm_mode = out_mode & ctrl_ff[`CCS_CTRL_MODE_HI - 1];

    ////////////////////////////////////////////////////////////////////////////
    // Event path

    // Edge pulses of the chosen source
    logic rise_w;
    logic fall_w;
    // Prescaler result and count
    logic fire_w;
    logic [`CCS_PS_W-1:0] ps_count;

    ccs_sync_edge u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .src_async({chip_src_in, pin_level_in}),
        .src_sel(src_ff),
        .rise(rise_w),
        .fall(fall_w)
    );

    wire logic edge_w = (mode == CCS_MODE_ANY) ? (rise_w | fall_w) :
                        (mode == CCS_MODE_FALL) ? fall_w : rise_w;
    // Divider per mode
    wire ccs_div_type div_w = (mode == CCS_MODE_RISE16) ? CCS_DIV16 :
                              (mode == CCS_MODE_RISE4) ? CCS_DIV4 : CCS_DIV1;

    // odd timer choice, first by default
    wire logic [`CCS_CNT_W-1:0] sel_count = (tsel_ff == 2'h3) ? tmr5_count :
                                            (tsel_ff == 2'h2) ? tmr3_count : tmr1_count;
    wire logic sel_ext = (tsel_ff == 2'h3) ? tmr_ext_clk[2] :
                         (tsel_ff == 2'h2) ? tmr_ext_clk[1] : tmr_ext_clk[0];
    wire logic cap_allow = ~sleep_in | sel_ext;
    wire logic tick_w = cap_mode & cap_allow & edge_w;

    // cleared when off or not capturing
    ccs_prescaler u_presc (
        .ref_clk(ref_clk),
        .rst_n(rst_sync_n),
        .clr(~cap_mode),
        .div_sel(div_w),
        .tick(tick_w),
        .fire(fire_w),
        .count(ps_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Capture data and flag

    // timers only read, so sharing is free
    // count taken as held, no local offset
    assign nxt_data = fire_w ? sel_count :
                      wr_hi ? {reg_wdata, data_ff[7:0]} :
                      wr_lo ? {data_ff[15:8], reg_wdata} : data_ff;

    // set wins over a software clear
    assign nxt_flag = fire_w | (flag_ff & ~(wr_stat & ~reg_wdata[`CCS_STAT_FLAG]));

    // Data and flag registers
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            data_ff <= `CCS_RST_DATA;
            flag_ff <= 1'b0;
        end else begin
            data_ff <= nxt_data;
            flag_ff <= nxt_flag;
        end
    end

    // Software control registers
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl_ff <= `CCS_RST_CTRL;
            src_ff <= `CCS_RST_SRC;
            tsel_ff <= `CCS_RST_TSEL;
            ie_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata;
            end
            if (wr_src) begin
                src_ff <= reg_wdata[`CCS_SRC_W-1:0];
            end
            if (wr_tsel) begin
                tsel_ff <= reg_wdata[`CCS_TSEL_W-1:0];
            end
            if (wr_stat) begin
                ie_ff <= reg_wdata[`CCS_STAT_IE];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path and outputs

    wire logic [`CCS_DATA_W-1:0] rd_mux =
        hit(reg_addr, `CCS_OFS_CTRL) ? ctrl_ff :
        hit(reg_addr, `CCS_OFS_SRC) ? {5'h00, src_ff} :
        hit(reg_addr, `CCS_OFS_DATA_LO) ? data_ff[7:0] :
        hit(reg_addr, `CCS_OFS_DATA_HI) ? data_ff[15:8] :
        hit(reg_addr, `CCS_OFS_TSEL) ? {6'h00, tsel_ff} :
        hit(reg_addr, `CCS_OFS_STAT) ? {6'h00, ie_ff, flag_ff} : 8'h00;

    // Timer number in use: odd for capture/compare, even for PWM
    wire logic [`CCS_TIDX_W-1:0] idx_base = (tsel_ff == 2'h3) ? 3'h5 :
                                            (tsel_ff == 2'h2) ? 3'h3 : 3'h1;
    // PWM moves to the even partner
    wire logic [`CCS_TIDX_W-1:0] idx_w = pwm_mode ? idx_base + 3'h1 : idx_base;

    wire logic od_w = ctrl_ff[`CCS_CTRL_OD];
    wire logic latch_w = ctrl_ff[`CCS_CTRL_LATCH];
    wire logic oe_w = out_mode & ~pin_direction_bit & (~od_w | ~latch_w);
    wire logic po_w = out_mode & ~od_w & latch_w;

    // Output registers; read data stand one cycle only
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_ff <= 8'h00;
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
            irq_ff <= 1'b0;
            strobe_ff <= 1'b0;
            tidx_ff <= 3'h1;
        end else begin
            rdata_ff <= reg_rd ? rd_mux : 8'h00;
            pin_out_ff <= po_w;
            pin_oe_ff <= oe_w;
            irq_ff <= nxt_flag & ie_ff;
            strobe_ff <= fire_w;
            tidx_ff <= idx_w;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign capture_interrupt_flag = flag_ff;
    assign capture_irq = irq_ff;
    assign capture_strobe = strobe_ff;
    assign assigned_timer_index = tidx_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync_n);

    a_capture_copies_count: assert property (fire_w |=> data_ff == $past(sel_count))
        else $error("captured value differs from timer count");
    a_falling_mode_fires: assert property (cap_mode && mode == CCS_MODE_FALL && fall_w && cap_allow |-> fire_w)
        else $error("falling edge did not capture");
    a_rise_mode_ignores: assert property (mode == CCS_MODE_RISE && !rise_w |-> !fire_w)
        else $error("capture without rising edge");
    a_flag_sets_holds: assert property (fire_w |=> flag_ff ##1 (flag_ff || $past(wr_stat)))
        else $error("capture flag not set or lost");
    a_overwrite_unread: assert property (fire_w ##[1:8] fire_w |=> data_ff == $past(sel_count))
        else $error("second capture did not overwrite");
    a_timer_default_odd: assert property ($past(cap_mode) && $past(tsel_ff) == 2'h0 |-> tidx_ff == 3'h1)
        else $error("default capture timer not the first");
    a_low_byte_read: assert property (reg_rd && reg_addr == `CCS_OFS_DATA_LO && !fire_w
                                      |=> reg_rdata == data_ff[7:0])
        else $error("low byte read mismatch");
    a_open_drain_low: assert property (out_mode && od_w |=> !pin_out)
        else $error("open-drain drove high");
    a_presc_cleared: assert property (!cap_mode |=> ps_count == 4'h0)
        else $error("prescaler not cleared outside capture");
    a_sleep_blocks: assert property (sleep_in && !sel_ext |-> !fire_w)
        else $error("capture in sleep with internal timer clock");
    a_strobe_follows: assert property (fire_w |=> capture_strobe ##1 !capture_strobe || $past(fire_w))
        else $error("strobe not one pulse per capture");

    c_capture_rise16: cover property (mode == CCS_MODE_RISE16 && fire_w);
    c_capture_any: cover property (mode == CCS_MODE_ANY && fall_w && fire_w);
    c_overwrite: cover property (fire_w ##[1:20] fire_w);
    c_flag_clear: cover property (flag_ff ##1 !flag_ff);

endmodule

// >>> dv/ccs_src_model.sv
// Far-side model: pad of the unit pin plus the four on-chip capture sources
`timescale 1ns/1ps
module ccs_src_model
    import ccs_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Requested source levels, bit0 = pin pad
    input wire logic [4:0] lvl_req,
    // Unit pin driver
    input wire logic pin_out,
    input wire logic pin_oe,
    // Levels seen by the unit
    output logic pin_level_in,
    output logic [3:0] chip_src_in
);
    // Levels change just after an edge, like real sources on this clock
    logic [4:0] lvl_ff;

    ////////////////////////////////////////////////////////////////////////
    // Source registers; levels only change at edges, so every pulse lasts whole cycles
    // whole-cycle pulses
    always_ff @(posedge ref_clk) begin
        lvl_ff <= lvl_req;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pad resolution: a driving unit wins over the outside level
    // pad sees driver
    assign pin_level_in = pin_oe ? pin_out : lvl_ff[0];
    assign chip_src_in = lvl_ff[4:1];
endmodule

// >>> dv/ccs_capture_unit_tb.sv
// Self-checking bench for the capture unit
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_capture_unit_tb
    import ccs_pkg::*;
;
    // Design stimulus and outputs
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic pin_level_in, pin_out, pin_oe;
    logic [3:0] chip_src_in;
    logic pin_direction_bit = 1'b1;
    logic [15:0] tmr1_count = 16'h1234;
    logic [15:0] tmr3_count = 16'h5678;
    logic [15:0] tmr5_count = 16'h9abc;
    logic [2:0] tmr_ext_clk = 3'h0;
    logic sleep_in = 1'b0;
    logic [2:0] assigned_timer_index;
    logic capture_interrupt_flag, capture_irq, capture_strobe;
    logic [4:0] lvl = 5'h00;
    // Counters
    int mismatches = 0;
    int checks = 0;
    int strobes = 0;
    int strobes_at = 0;

    ccs_capture_unit ccs_capture_unit_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_level_in(pin_level_in), .chip_src_in(chip_src_in), .pin_direction_bit(pin_direction_bit),
        .pin_out(pin_out), .pin_oe(pin_oe), .tmr1_count(tmr1_count), .tmr3_count(tmr3_count),
        .tmr5_count(tmr5_count), .tmr_ext_clk(tmr_ext_clk), .sleep_in(sleep_in),
        .assigned_timer_index(assigned_timer_index), .capture_interrupt_flag(capture_interrupt_flag),
        .capture_irq(capture_irq), .capture_strobe(capture_strobe));

    ccs_src_model ccs_src_model_inst (.ref_clk(ref_clk), .lvl_req(lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level_in(pin_level_in), .chip_src_in(chip_src_in));

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Count capture pulses; each is one cycle long
    always @(posedge ref_clk) begin
        if (capture_strobe === 1'b1) strobes++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Bus cycles: strobe one cycle, read data stands in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask

    // Flip one source and let the sync pipeline settle
    task automatic tog(input int s);
        lvl[s] <= ~lvl[s];
        repeat (8) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenario: register reset values, unmapped place, default timer
    task automatic t_reset();
        logic [7:0] d;
        wr(8'h07, 8'hff);
        for (int a = 0; a < 8; a++) begin
            rd(a[7:0], d);
            chk(d, 16'h0000);
        end
        chk(assigned_timer_index, 16'h0001);
    endtask

    // Scenario: n pulses (two toggles each) of source s in a mode, count the captures
    task automatic cap_mode(input ccs_mode_type m, input int n, input int s, input int exp);
        int base;
        // Off first so a prescaler change starts from zero
        wr(`CCS_OFS_CTRL, 8'h00);
        wr(`CCS_OFS_CTRL, {4'h8, m});
        // Interrupt enable and flag both cleared after the change
        wr(`CCS_OFS_STAT, 8'h00);
        base = strobes;
        for (int i = 0; i < n; i++) begin
            tog(s);
            tog(s);
        end
        chk(16'(strobes - base), 16'(exp));
    endtask

    // Scenario: captured value is the whole count, newest capture wins
    task automatic t_data();
        logic [7:0] lo, hi;
        cap_mode(CCS_MODE_RISE, 1, 0, 1);
        // Timer held steady while capturing, as a synchronous count
        tmr1_count <= 16'hc3a5;
        tog(0);
        tog(0);
        // Pair read, then low byte read again, so both halves belong to one event
        rd(`CCS_OFS_DATA_LO, lo);
        rd(`CCS_OFS_DATA_HI, hi);
        chk({hi, lo}, 16'hc3a5);
        rd(`CCS_OFS_DATA_LO, lo);
        chk(lo, 16'h00a5);
    endtask

    // Scenario: flag sticks, gated request, software clear
    task automatic t_flag();
        logic [7:0] d;
        wr(`CCS_OFS_STAT, 8'h02);
        tog(0);
        tog(0);
        repeat (20) @(posedge ref_clk);
        chk(capture_interrupt_flag, 16'h0001);
        chk(capture_irq, 16'h0001);
        wr(`CCS_OFS_STAT, 8'h03);
        chk(capture_interrupt_flag, 16'h0001);
        wr(`CCS_OFS_STAT, 8'h02);
        rd(`CCS_OFS_STAT, d);
        chk(d, 16'h0002);
        chk(capture_irq, 16'h0000);
    endtask

    // Scenario: timer select picks odd timers only
    task automatic t_timer();
        logic [7:0] lo, hi;
        logic [15:0] exp_cnt [4];
        logic [2:0] exp_idx [4];
        exp_cnt = '{16'hc3a5, 16'hc3a5, 16'h5678, 16'h9abc};
        exp_idx = '{3'h1, 3'h1, 3'h3, 3'h5};
        for (int t = 0; t < 4; t++) begin
            wr(`CCS_OFS_TSEL, t[7:0]);
            tog(0);
            tog(0);
            chk(assigned_timer_index, exp_idx[t]);
            rd(`CCS_OFS_DATA_LO, lo);
            rd(`CCS_OFS_DATA_HI, hi);
            chk({hi, lo}, exp_cnt[t]);
        end
        wr(`CCS_OFS_TSEL, 8'h00);
    endtask

    // Scenario: output pin driver, push-pull and open-drain
    task automatic t_pin();
        logic [7:0] ctl [4];
        logic [1:0] exp [4];
        ctl = '{8'h88, 8'ha8, 8'h98, 8'hb8};
        exp = '{2'b10, 2'b11, 2'b10, 2'b00};
        pin_direction_bit <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(`CCS_OFS_CTRL, ctl[i]);
            // Pin flops load one edge after the control write lands
            repeat (2) @(posedge ref_clk);
            chk({pin_oe, pin_out}, exp[i]);
        end
        // PWM moves the timer number to the even partner
        wr(`CCS_OFS_CTRL, 8'h8c);
        repeat (2) @(posedge ref_clk);
        chk(assigned_timer_index, 16'h0002);
        pin_direction_bit <= 1'b1;
        wr(`CCS_OFS_CTRL, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        cap_mode(CCS_MODE_FALL, 16, 0, 16);
        cap_mode(CCS_MODE_RISE, 16, 0, 16);
        cap_mode(CCS_MODE_ANY, 16, 0, 32);
        cap_mode(CCS_MODE_RISE4, 16, 0, 4);
        cap_mode(CCS_MODE_RISE16, 16, 0, 1);
        cap_mode(CCS_MODE_OFF, 4, 0, 0);
        // Leftover count must not survive a turn-off
        cap_mode(CCS_MODE_RISE4, 3, 0, 0);
        cap_mode(CCS_MODE_RISE4, 3, 0, 0);
        // Count kept while capturing: the fourth rise fires
        strobes_at = strobes;
        tog(0);
        tog(0);
        chk(16'(strobes - strobes_at), 16'h0001);
        for (int s = 1; s < 5; s++) begin
            wr(`CCS_OFS_SRC, s[7:0]);
            cap_mode(CCS_MODE_RISE, 2, s, 2);
            cap_mode(CCS_MODE_RISE, 2, 0, 0);
        end
        wr(`CCS_OFS_SRC, 8'h05);
        // Pin set as output by the port: its level is still watched
        pin_direction_bit <= 1'b0;
        cap_mode(CCS_MODE_RISE, 2, 0, 2);
        pin_direction_bit <= 1'b1;
        wr(`CCS_OFS_SRC, 8'h00);
        t_data();
        t_flag();
        t_timer();
        // Sleep: internal timer clock stops capture, external keeps it
        sleep_in <= 1'b1;
        cap_mode(CCS_MODE_RISE, 2, 0, 0);
        tmr_ext_clk <= 3'h1;
        cap_mode(CCS_MODE_RISE, 2, 0, 2);
        sleep_in <= 1'b0;
        tmr_ext_clk <= 3'h0;
        t_pin();
        final_report();
    end
endmodule
